//--- rtl/ltm_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the received bus level from the buffer to its consumer
interface ltm_buf_if;
	logic in_valid;
	logic in_ready;
	logic in_data;
	logic out_valid;
	logic out_ready;
	logic out_data;
	modport buf_side (input in_valid, output in_ready, input in_data,
		output out_valid, input out_ready, output out_data);
	modport user_side (output in_valid, input in_ready, output in_data,
		input out_valid, output out_ready, input out_data);
endinterface : ltm_buf_if
`default_nettype wire

//--- rtl/ltm_core.sv
`timescale 1ns/1ps
`default_nettype none
module ltm_core #(
	parameter int EN_CYCLES = ltm_pkg::EN_CYC,
	parameter int WAKE_CYCLES = ltm_pkg::WAKE_CYC,
	parameter int TXTO_CYCLES = ltm_pkg::TXTO_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] sys_mode,
	input wire logic mode_wr,
	input wire logic [1:0] mode_wdata,
	output logic [1:0] mode_rdata,
	input wire logic lin_tx_input,
	output logic lin_rx_output,
	input wire logic lin_bus_in,
	output logic lin_bus_out,
	output logic lin_bus_oe,
	output logic wake_event,
	output logic wake_status_reg,
	input wire logic wake_status_clr,
	output logic first_lin_fault_flag,
	input wire logic fault_clr,
	input wire logic rx_sample_ready
);
	// ***********************************
	// Declarations
	// ***********************************
	logic [1:0] mode_q;
	logic [1:0] tx_sync_q;
	logic [1:0] bus_sync_q;
	logic tx_s;
	logic bus_s;
	logic bus_prev_q;
	logic [31:0] en_cnt_q;
	logic en_done_q;
	logic armed_q;
	logic [31:0] wk_cnt_q;
	logic wk_long_q;
	logic woken_q;
	logic [31:0] to_cnt_q;
	logic to_q;
	logic sys_nm_stop;
	logic drive;
	logic rx_level;
	logic [2:0] sys_prev_q;
	logic sys_rearm;
	ltm_buf_if bif ();

	assign tx_s = tx_sync_q[1];
	assign bus_s = bus_sync_q[1];
	assign sys_nm_stop = (sys_mode == ltm_pkg::LTM_SYS_NORMAL) || (sys_mode == ltm_pkg::LTM_SYS_STOP);

	// ***********************************
	// Pin synchronisers
	// ***********************************
	// Two stages each; the first stage feeds nothing else
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_sync_q <= 2'h3;
			bus_sync_q <= 2'h3;
			bus_prev_q <= 1'b1;
		end else begin
			tx_sync_q <= {tx_sync_q[0], lin_tx_input};
			bus_sync_q <= {bus_sync_q[0], lin_bus_in};
			bus_prev_q <= bus_s;
		end
	end

	// ***********************************
	// Mode register
	// ***********************************
	// off at reset; SPI selection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= ltm_pkg::MODE_RST;
		end else if (mode_wr) begin
			case (mode_wdata)
				ltm_pkg::LTM_OFF: mode_q <= mode_wdata;
				ltm_pkg::LTM_NORMAL: begin
					if (sys_nm_stop) begin
						mode_q <= mode_wdata;
					end
				end
				ltm_pkg::LTM_RXONLY: begin
					if (sys_nm_stop) begin
						mode_q <= mode_wdata;
					end
				end
				ltm_pkg::LTM_WAKE: begin
					if (sys_mode != ltm_pkg::LTM_SYS_INIT) begin
						mode_q <= mode_wdata;
					end
				end
				default: mode_q <= mode_q;
			endcase
		end
	end
	assign mode_rdata = mode_q;

	// ***********************************
	// Enabling sequence
	// ***********************************
	// enabling counter restarts on entry to normal
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_cnt_q <= 32'h0;
			en_done_q <= 1'b0;
		end else if (mode_q != ltm_pkg::LTM_NORMAL || mode_wr) begin
			en_cnt_q <= 32'h0;
			en_done_q <= 1'b0;
		end else if (!en_done_q) begin
			en_cnt_q <= en_cnt_q + 32'h1;
			en_done_q <= (en_cnt_q + 32'h1 >= 32'(EN_CYCLES));
		end
	end
	// armed only after input seen high post-enable
	// early low is simply held off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (!en_done_q) begin
			armed_q <= 1'b0;
		end else if (tx_s) begin
			armed_q <= 1'b1;
		end
	end

	// ***********************************
	// Transmit time-out
	// ***********************************
	// long dominant input blocks driver
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			to_cnt_q <= 32'h0;
			to_q <= 1'b0;
		end else if (tx_s || mode_q != ltm_pkg::LTM_NORMAL) begin
			to_cnt_q <= 32'h0;
			to_q <= 1'b0;
		end else if (!to_q) begin
			to_cnt_q <= to_cnt_q + 32'h1;
			to_q <= (to_cnt_q + 32'h1 >= 32'(TXTO_CYCLES));
		end
	end
	// sticky fault; set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_lin_fault_flag <= 1'b0;
		end else if (to_q) begin
			first_lin_fault_flag <= 1'b1;
		end else if (fault_clr) begin
			first_lin_fault_flag <= 1'b0;
		end
	end

	// ***********************************
	// Bus driver
	// ***********************************
	// dominant while input low; off otherwise
	assign drive = (mode_q == ltm_pkg::LTM_NORMAL) && armed_q && !tx_s && !to_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lin_bus_out <= 1'b1;
			lin_bus_oe <= 1'b0;
		end else begin
			lin_bus_out <= 1'b0;
			lin_bus_oe <= drive;
		end
	end

	// ***********************************
	// Wake detection
	// ***********************************
	// filtered dominant then rising edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wk_cnt_q <= 32'h0;
			wk_long_q <= 1'b0;
		end else if (mode_q != ltm_pkg::LTM_WAKE || bus_s) begin
			wk_cnt_q <= 32'h0;
			wk_long_q <= bus_s && wk_long_q && mode_q == ltm_pkg::LTM_WAKE && !bus_prev_q;
		end else if (!wk_long_q) begin
			wk_cnt_q <= wk_cnt_q + 32'h1;
			wk_long_q <= (wk_cnt_q + 32'h1 > 32'(WAKE_CYCLES));
		end
	end
	// Pulse when a long dominant ends; only in wake mode
	assign wake_event = (mode_q == ltm_pkg::LTM_WAKE) && !woken_q && wk_long_q && bus_s
		&& !bus_prev_q;
	// Previous system mode; rearm only on entry, else a wake in stop vanishes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_prev_q <= ltm_pkg::LTM_SYS_INIT;
		end else begin
			sys_prev_q <= sys_mode;
		end
	end
	assign sys_rearm = (sys_mode != sys_prev_q) && ((sys_mode == ltm_pkg::LTM_SYS_STOP)
		|| (sys_mode == ltm_pkg::LTM_SYS_SLEEP) || (sys_mode == ltm_pkg::LTM_SYS_FAILSAFE));
	// latched until mode change; rearm on entry to low power
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			woken_q <= 1'b0;
		end else if (wake_event) begin
			woken_q <= 1'b1;
		end else if ((mode_wr && mode_wdata != ltm_pkg::LTM_WAKE)
			|| mode_q != ltm_pkg::LTM_WAKE || sys_rearm) begin
			woken_q <= 1'b0;
		end
	end
	// Wake status; set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_status_reg <= 1'b0;
		end else if (wake_event) begin
			wake_status_reg <= 1'b1;
		end else if (wake_status_clr) begin
			wake_status_reg <= 1'b0;
		end
	end

	// ***********************************
	// Receive path
	// ***********************************
	// bus level; low after wake; off reads high
	always_comb begin
		case (mode_q)
			ltm_pkg::LTM_NORMAL: rx_level = bus_s;
			ltm_pkg::LTM_RXONLY: rx_level = bus_s;
			ltm_pkg::LTM_WAKE: rx_level = !woken_q;
			default: rx_level = 1'b1;
		endcase
	end
	assign bif.in_valid = 1'b1;
	assign bif.in_data = rx_level;
	assign bif.out_ready = rx_sample_ready;
	ltm_skid u_skid (
		.clk(clk),
		.rst(rst),
		.b(bif)
	);
	// Output holds last word when the consumer stalls
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lin_rx_output <= 1'b1;
		end else if (bif.out_valid && bif.out_ready) begin
			lin_rx_output <= bif.out_data;
		end
	end
endmodule : ltm_core
`default_nettype wire

//--- rtl/ltm_pkg.sv
`default_nettype none
package ltm_pkg;
	// Transceiver mode encoding as written over SPI
	typedef enum logic [1:0] {
		LTM_OFF = 2'h0,
		LTM_WAKE = 2'h1,
		LTM_RXONLY = 2'h2,
		LTM_NORMAL = 2'h3
	} ltm_mode_e;
	// System chip operating modes
	typedef enum logic [2:0] {
		LTM_SYS_INIT = 3'h0,
		LTM_SYS_NORMAL = 3'h1,
		LTM_SYS_STOP = 3'h2,
		LTM_SYS_SLEEP = 3'h3,
		LTM_SYS_RESTART = 3'h4,
		LTM_SYS_FAILSAFE = 3'h5
	} ltm_sys_e;
	localparam int CLK_HZ = 10000000;
	localparam int EN_TIME_US = 10;
	localparam int WAKE_FILT_US = 50;
	localparam int TXTO_US = 10000;
	localparam int EN_CYC = (EN_TIME_US * (CLK_HZ / 1000000) < 1) ? 1 : EN_TIME_US * (CLK_HZ / 1000000);
	localparam int WAKE_CYC = WAKE_FILT_US * (CLK_HZ / 1000000);
	localparam int TXTO_CYC = TXTO_US * (CLK_HZ / 1000000);
	localparam logic [1:0] MODE_RST = 2'h0;
endpackage : ltm_pkg
`default_nettype wire

//--- rtl/ltm_skid.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// Two-entry buffer for bus samples
// ***********************************
module ltm_skid (
	input wire logic clk,
	input wire logic rst,
	ltm_buf_if.buf_side b
);
	logic [1:0] mem_q;
	logic [1:0] cnt_q;
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic push;
	logic pop;
	// Handshakes; full refuses input so nothing is overwritten
	assign b.in_ready = (cnt_q != 2'h2);
	assign b.out_valid = (cnt_q != 2'h0);
	assign b.out_data = mem_q[rd_ptr_q];
	assign push = b.in_valid && b.in_ready;
	assign pop = b.out_valid && b.out_ready;
	// Storage and pointers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_q <= 2'h3;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= b.in_data;
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
		end
	end
	// Fill level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 2'h0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 2'h1;
		end
	end
endmodule : ltm_skid
`default_nettype wire

//--- sim/ltm_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Port checker for the core
// ****************************
module ltm_core_assertions #(
	parameter int TXTO_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] sys_mode,
	input wire logic mode_wr,
	input wire logic [1:0] mode_wdata,
	input wire logic [1:0] mode_rdata,
	input wire logic lin_bus_out,
	input wire logic lin_bus_oe,
	input wire logic wake_event,
	input wire logic wake_status_reg,
	input wire logic first_lin_fault_flag,
	input wire logic fault_clr
);
	int oe_n;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Run length of driving, bounded by the timeout
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oe_n <= 0;
		end else begin
			oe_n <= lin_bus_oe ? oe_n + 1 : 0;
		end
	end
	refuse_normal_a: assert property (
		mode_wr && mode_wdata == 2'h3 && !(sys_mode inside {3'h1, 3'h2}) |=> $stable(mode_rdata))
		else $error("refused normal changed mode");
	off_write_a: assert property (
		mode_wr && mode_wdata == 2'h0 |=> mode_rdata == 2'h0) else $error("off not taken");
	off_no_wake_a: assert property (
		mode_rdata == 2'h0 |-> !wake_event) else $error("wake in off mode");
	drive_mode_a: assert property (
		mode_rdata != 2'h3 && $past(mode_rdata) != 2'h3 |-> !lin_bus_oe) else $error("drive off normal");
	wake_set_a: assert property (
		wake_event |=> wake_status_reg && mode_rdata == 2'h1) else $error("wake not held");
	oe_data_a: assert property (
		lin_bus_oe |-> !lin_bus_out) else $error("driving recessive");
	enable_wait_a: assert property (
		$rose(mode_rdata == 2'h3) |-> !lin_bus_oe [*3]) else $error("drive before enabled");
	tx_timeout_a: assert property (
		oe_n <= TXTO_CYCLES + 2) else $error("dominant past timeout");
	cover property (wake_event);
	cover property ($rose(first_lin_fault_flag));
	cover property ($rose(lin_bus_oe));
endmodule : ltm_core_assertions
`default_nettype wire

//--- sim/ltm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ltm_core_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] sys = 3'h0;
	logic wr_p = 1'b0;
	logic [1:0] wd = 2'h0;
	logic wclr = 1'b0;
	logic fclr = 1'b0;
	logic rdy = 1'b1;
	logic ext_low = 1'b0;
	logic tx, rx, out, oe, wev, wk, flt;
	logic [1:0] mode;
	int n_errors = 0;
	int checks_done = 0;
	// Wired bus with pull-up
	wire logic bus = !(oe && !out) && !ext_low;
	wire logic [3:0] st = {oe, rx, wk, flt};
	// Clock at 10 MHz
	always #50 clk = ~clk;
	ltm_mcu_model #(.EN(4)) ltm_mcu_model_i (.clk(clk), .tx(tx), .rx(rx));
	ltm_core #(.EN_CYCLES(4), .WAKE_CYCLES(8), .TXTO_CYCLES(20)) ltm_core_i (.clk(clk),
		.rst(rst), .sys_mode(sys), .mode_wr(wr_p), .mode_wdata(wd), .mode_rdata(mode),
		.lin_tx_input(tx), .lin_rx_output(rx), .lin_bus_in(bus), .lin_bus_out(out),
		.lin_bus_oe(oe), .wake_event(wev), .wake_status_reg(wk), .wake_status_clr(wclr),
		.first_lin_fault_flag(flt), .fault_clr(fclr), .rx_sample_ready(rdy));
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One-cycle mode write pulse
	task automatic wr(input logic [1:0] m);
		@(negedge clk);
		wr_p = 1'b1;
		wd = m;
		@(negedge clk);
		wr_p = 1'b0;
	endtask : wr
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	// Watchdog, ten times the expected run
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		close_out();
	end
	// Test sequence
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk({mode, st[3:2]}, 4'h1);
		$display("test reset done");
		for (int s = 0; s < 6; s++) begin
			sys = 3'(s);
			for (int m = 1; m < 4; m++) begin
				wr(2'h0);
				wr(2'(m));
				chk({2'h0, mode}, ((m == 1) ? s != 0 : (s == 1 || s == 2)) ? 4'(m) : 4'h0);
			end
		end
		wr(2'h1);
		wr(2'h3);
		chk({2'h0, mode}, 4'h1);
		$display("test mode table done");
		sys = 3'h1;
		wr(2'h3);
		ltm_mcu_model_i.drive(1'b0, 8);
		chk(st, 4'h4);
		ltm_mcu_model_i.drive(1'b1, 3);
		ltm_mcu_model_i.drive(1'b0, 8);
		chk(st, 4'h8);
		ltm_mcu_model_i.drive(1'b1, 9);
		chk(st, 4'h4);
		$display("test enabling done");
		ltm_mcu_model_i.drive(1'b0, 30);
		chk(st, 4'h5);
		ltm_mcu_model_i.settle();
		fclr = 1'b1;
		@(negedge clk) fclr = 1'b0;
		ltm_mcu_model_i.drive(1'b0, 8);
		chk(st, 4'h8);
		ltm_mcu_model_i.settle();
		$display("test timeout done");
		sys = 3'h2;
		wr(2'h2);
		ltm_mcu_model_i.drive(1'b0, 8);
		ext_low = 1'b1;
		repeat (8) @(negedge clk);
		chk(st, 4'h0);
		rdy = 1'b0;
		ext_low = 1'b0;
		ltm_mcu_model_i.drive(1'b1, 8);
		chk(st, 4'h0);
		rdy = 1'b1;
		repeat (8) @(negedge clk);
		chk(st, 4'h4);
		$display("test receive only done");
		for (int m = 1; m >= 0; m--) begin
			wr(2'(m));
			ext_low = 1'b1;
			repeat (3) @(negedge clk);
			ext_low = 1'b0;
			repeat (8) @(negedge clk);
			chk({3'h0, wk}, 4'h0);
			ext_low = 1'b1;
			repeat (12) @(negedge clk);
			ext_low = 1'b0;
			repeat (8) @(negedge clk);
			chk({mode, rx, wk}, m ? 4'h5 : 4'h2);
			wclr = 1'b1;
			@(negedge clk) wclr = 1'b0;
		end
		$display("test wake done");
		close_out();
	end
endmodule : ltm_core_tb
bind ltm_core ltm_core_assertions #(.TXTO_CYCLES(TXTO_CYCLES)) chk_i (.clk(clk), .rst(rst),
	.sys_mode(sys_mode), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .mode_rdata(mode_rdata),
	.lin_bus_out(lin_bus_out), .lin_bus_oe(lin_bus_oe), .wake_event(wake_event),
	.wake_status_reg(wake_status_reg), .first_lin_fault_flag(first_lin_fault_flag),
	.fault_clr(fault_clr));
`default_nettype wire

//--- sim/ltm_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Controller on the pin side
// ****************************
module ltm_mcu_model #(
	parameter int EN = 4
) (
	input wire logic clk,
	output var logic tx,
	input wire logic rx
);
	// Pin idles recessive from time zero
	initial tx = 1'b1;
	// Level held whole cycles, changed at the falling edge
	task automatic drive(input logic v, input int n);
		@(negedge clk);
		tx = v;
		repeat (n - 1) @(negedge clk);
	endtask : drive
	task automatic settle();
		drive(1'b1, EN + 2);
	endtask : settle
endmodule : ltm_mcu_model
`default_nettype wire
